// ===== rtl/hrf_rx_queue.sv
// module: hdlc receive queue with block handshake and avalon register slave
// What this block does
// - 64-byte cyclic receive store; block size 4, 8, 16 or 32 by select field.
// - block size select resets to the 32-byte code.
// - block-ready event when a full block is stored and the frame continues.
// - message-end event when a frame's last part and status are stored.
// - frame arriving into a full store is dropped whole; frame-lost flag set.
// - release frees the current block; after a frame end with no event queued the count reads zero.
// - receiver-clear resets receive logic and empties the store.
// - 12-bit frame length count in two registers; wrap flag beyond 4095.
// - low count bits give last-block bytes, upper bits full blocks.
// - last-block count of zero means a full block.
// - working block size loads only on release or receiver-clear.
// - store holds several frames; a status byte follows each frame's data.
// - events are queued; next one shows right after release.
// - partial loss of a frame sets its data-loss status bit.
// - reading past the block wraps to the block's first byte.
// - release drops the whole block, read or not.
// - data reads with no pending event return zero and disturb nothing.
// - status byte always carries crc, valid, abort and loss; tei except mode 110.
// - cr and sapi code only in two-byte full-address and sapi mode.
// - message-end count includes the status byte.
// - in mode 110 every byte handed in is stored.
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module hrf_rx_queue (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic rx_byte_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_first_in,
  input wire logic rx_end_in,
  input wire logic rx_crc_ok_in,
  input wire logic rx_valid_frame_in,
  input wire logic rx_abort_in,
  input wire logic rx_tei_match_in,
  input wire logic rx_cr_in,
  input wire logic [1:0] rx_sapi_match_in,
  output logic rx_ready_out
);

  hrf_pkg::hrf_state_t state_q;
  hrf_pkg::hrf_state_t state_d;

  // ----------------------------------------
  // head of the event queue
  // ----------------------------------------
  logic head_valid;
  logic [5:0] head_start;
  logic [5:0] head_len;
  logic [12:0] head_cnt;
  logic [5:0] head_addr;
  logic req;
  logic take;
  logic wr_ok;
  logic do_clear;
  logic do_release;
  logic [31:0] rd_mux;

  assign head_valid = (state_q.q_num != 6'h00);
  assign head_start = state_q.q_start[state_q.q_rd];
  assign head_len = state_q.q_len[state_q.q_rd];
  assign head_cnt = head_valid ? state_q.q_cnt[state_q.q_rd] : 13'h0000;
  assign head_addr = head_start + state_q.rd_off;
  assign req = avs_read_in | avs_write_in;
  assign take = req & ~state_q.wait_q;
  assign wr_ok = take & avs_write_in & avs_byteenable_in[0];
  assign do_clear = wr_ok & (avs_address_in == hrf_pkg::ADDR_CMD)
                    & avs_writedata_in[hrf_pkg::CMD_CLEAR_BIT];
  assign do_release = wr_ok & (avs_address_in == hrf_pkg::ADDR_CMD)
                      & avs_writedata_in[hrf_pkg::CMD_RELEASE_BIT] & ~do_clear;

  // ----------------------------------------
  // read multiplexer
  // ----------------------------------------
  always_comb begin
    case (avs_address_in)
      hrf_pkg::ADDR_DATA: rd_mux = {24'h000000, head_valid ? state_q.mem[head_addr] : 8'h00};
      hrf_pkg::ADDR_CNT_LO: rd_mux = {24'h000000, head_cnt[7:0]};
      hrf_pkg::ADDR_CNT_HI: rd_mux = {27'h0000000, head_cnt[12:8]};
      hrf_pkg::ADDR_IRQ: rd_mux = {29'h00000000, state_q.lost,
                                   head_valid & state_q.q_end[state_q.q_rd],
                                   head_valid & ~state_q.q_end[state_q.q_rd]};
      hrf_pkg::ADDR_MODE: rd_mux = {27'h0000000, state_q.fmode, state_q.bs_sel};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [7:0] sb;
    sb = 8'h00;
    state_d = state_q;
    // one wait cycle per access; data is sampled while the request is held
    if (req && state_q.wait_q) begin
      state_d.wait_q = 1'b0;
      state_d.rdata = rd_mux;
    end else begin
      state_d.wait_q = 1'b1;
    end
    if (take && avs_read_in) begin
      if (avs_address_in == hrf_pkg::ADDR_DATA && head_valid) begin
        if (state_q.rd_off + 6'h01 == head_len) begin
          state_d.rd_off = 6'h00;
        end else begin
          state_d.rd_off = state_q.rd_off + 6'h01;
        end
      end
      if (avs_address_in == hrf_pkg::ADDR_IRQ) state_d.lost = 1'b0;
    end
    if (wr_ok && avs_address_in == hrf_pkg::ADDR_MODE) begin
      state_d.bs_sel = avs_writedata_in[hrf_pkg::MODE_BS_LSB +: 2];
      state_d.fmode = avs_writedata_in[hrf_pkg::MODE_FM_LSB +: 3];
    end
    if (do_clear) begin
      state_d.used = 7'h00;
      state_d.wp = 6'h00;
      state_d.q_rd = 5'h00;
      state_d.q_wr = 5'h00;
      state_d.q_num = 6'h00;
      state_d.rd_off = 6'h00;
      state_d.st = hrf_pkg::RX_IDLE;
      state_d.lost = 1'b0;
      state_d.wbs = hrf_pkg::blk_size(state_q.bs_sel);
    end
    if (do_release) begin
      state_d.wbs = hrf_pkg::blk_size(state_q.bs_sel);
      if (head_valid) begin
        state_d.used = state_q.used - {1'b0, head_len};
        state_d.q_rd = state_q.q_rd + 5'h01;
        state_d.q_num = state_q.q_num - 6'h01;
        state_d.rd_off = 6'h00;
      end
    end
    // receive side; a clear in the same cycle wins over any arriving byte
    if (!do_clear) begin
      if (state_q.st == hrf_pkg::RX_TAIL) begin
        state_d = hrf_pkg::push_ev(state_d, 1'b1, state_q.blk_start, 6'h01);
        state_d.st = hrf_pkg::RX_IDLE;
      end else if (rx_byte_valid_in && rx_first_in) begin
        if (state_q.used >= hrf_pkg::ROOM_LIMIT || state_q.q_num >= hrf_pkg::Q_LIMIT) begin
          state_d.lost = 1'b1;
          state_d.st = hrf_pkg::RX_DROP;
        end else begin
          state_d.blk_start = state_q.wp;
          state_d.blk_cnt = 6'h00;
          state_d.flen = 12'h000;
          state_d.fov = 1'b0;
          state_d.floss = 1'b0;
          state_d = hrf_pkg::store_byte(state_d, rx_byte_in);
          state_d.st = hrf_pkg::RX_DATA;
        end
      end else if (state_q.st == hrf_pkg::RX_DATA && rx_byte_valid_in) begin
        // one slot always stays free for the status byte
        if (state_q.used < hrf_pkg::ROOM_LIMIT && state_q.q_num < hrf_pkg::Q_LIMIT) begin
          if (state_q.blk_cnt == state_q.wbs) begin
            state_d = hrf_pkg::push_ev(state_d, 1'b0, state_q.blk_start, state_q.wbs);
            state_d.blk_start = state_q.wp;
            state_d.blk_cnt = 6'h00;
          end
          state_d = hrf_pkg::store_byte(state_d, rx_byte_in);
        end else begin
          state_d.floss = 1'b1;
        end
      end else if (state_q.st == hrf_pkg::RX_DATA && rx_end_in) begin
        sb[hrf_pkg::ST_VFR] = rx_valid_frame_in;
        sb[hrf_pkg::ST_RDO] = state_q.floss;
        sb[hrf_pkg::ST_CRC] = rx_crc_ok_in;
        sb[hrf_pkg::ST_RAB] = rx_abort_in;
        if (state_q.fmode != hrf_pkg::FM_TRANSP0) sb[hrf_pkg::ST_TA] = rx_tei_match_in;
        if (state_q.fmode == hrf_pkg::FM_FULL_ADDR2 || state_q.fmode == hrf_pkg::FM_TRANSP1) begin
          sb[hrf_pkg::ST_SA +: 2] = rx_sapi_match_in;
          sb[hrf_pkg::ST_CR] = rx_cr_in;
        end
        if (state_q.blk_cnt == state_q.wbs) begin
          // full last block: ready event now, status alone ends the frame next cycle
          state_d = hrf_pkg::push_ev(state_d, 1'b0, state_q.blk_start, state_q.wbs);
          state_d.blk_start = state_q.wp;
          state_d.blk_cnt = 6'h00;
          state_d = hrf_pkg::store_byte(state_d, sb);
          state_d.st = hrf_pkg::RX_TAIL;
        end else begin
          state_d = hrf_pkg::store_byte(state_d, sb);
          state_d = hrf_pkg::push_ev(state_d, 1'b1, state_q.blk_start, state_d.blk_cnt);
          state_d.st = hrf_pkg::RX_IDLE;
        end
      end else if (state_q.st == hrf_pkg::RX_DROP && rx_end_in) begin
        state_d.st = hrf_pkg::RX_IDLE;
      end
    end
    state_d.rx_ready = (state_d.st != hrf_pkg::RX_TAIL);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= hrf_pkg::STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign avs_readdata_out = state_q.rdata;
  assign avs_waitrequest_out = state_q.wait_q;
  assign rx_ready_out = state_q.rx_ready;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  logic rx_quiet;
  logic data_rd;
  assign rx_quiet = ~rx_byte_valid_in & ~rx_end_in & (state_q.st != hrf_pkg::RX_TAIL);
  assign data_rd = take & avs_read_in & (avs_address_in == hrf_pkg::ADDR_DATA);

  property p_wait_one;
    req && state_q.wait_q |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest not one cycle low");

  property p_size_load;
    do_clear || do_release |=> state_q.wbs == hrf_pkg::blk_size($past(state_q.bs_sel));
  endproperty
  a_size_load: assert property (p_size_load) else $error("block size not loaded");

  property p_lost;
    rx_byte_valid_in && rx_first_in && !do_clear && state_q.st != hrf_pkg::RX_TAIL
      && state_q.used >= hrf_pkg::ROOM_LIMIT |=> state_q.lost && state_q.st == hrf_pkg::RX_DROP;
  endproperty
  a_lost: assert property (p_lost) else $error("full store did not drop frame");

  property p_release;
    do_release && head_valid && rx_quiet
      |=> state_q.used == $past(state_q.used) - {1'b0, $past(head_len)} && state_q.rd_off == 6'h00;
  endproperty
  a_release: assert property (p_release) else $error("release did not free block");

  property p_clear;
    do_clear |=> state_q.used == 7'h00 && !head_valid && state_q.st == hrf_pkg::RX_IDLE;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left data");

  property p_wrap;
    data_rd && head_valid && !do_release && state_q.rd_off + 6'h01 == head_len
      |=> state_q.rd_off == 6'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("read did not wrap in block");

  property p_idle_read;
    data_rd && !head_valid && rx_quiet |=> $stable(state_q.rd_off) && $stable(state_q.used);
  endproperty
  a_idle_read: assert property (p_idle_read) else $error("idle read changed store");

  property p_wrap_flag;
    $rose(state_q.fov) |-> $past(state_q.flen) == hrf_pkg::LEN_MAX;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("length wrap flag early");

  property p_tail;
    state_q.st == hrf_pkg::RX_TAIL && !do_clear
      |=> state_q.st == hrf_pkg::RX_IDLE && state_q.q_end[$past(state_q.q_wr)];
  endproperty
  a_tail: assert property (p_tail) else $error("tail end event missing");

  c_release_end: cover property (do_release && head_valid && state_q.q_end[state_q.q_rd]);
  c_frame_lost: cover property ($rose(state_q.lost));
  c_tail: cover property (state_q.st == hrf_pkg::RX_TAIL);
  c_wrap_read: cover property (data_rd && head_valid && state_q.rd_off + 6'h01 == head_len);

endmodule

// ===== rtl/hrf_pkg.sv
// package: constants, types and helpers of the hdlc receive queue controller
package hrf_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_CNT_LO = 8'h04;
  localparam logic [7:0] ADDR_CNT_HI = 8'h08;
  localparam logic [7:0] ADDR_IRQ = 8'h0c;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_CMD = 8'h14;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CMD_RELEASE_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  localparam int MODE_BS_LSB = 0;
  localparam int MODE_FM_LSB = 2;
  localparam logic [1:0] BS_RESET = 2'h0;
  localparam logic [2:0] FM_RESET = 3'h6;
  localparam logic [2:0] FM_TRANSP0 = 3'h6;
  localparam logic [2:0] FM_TRANSP1 = 3'h7;
  localparam logic [2:0] FM_FULL_ADDR2 = 3'h3;
  // status byte layout
  localparam int ST_VFR = 7;
  localparam int ST_RDO = 6;
  localparam int ST_CRC = 5;
  localparam int ST_RAB = 4;
  localparam int ST_TA = 3;
  localparam int ST_SA = 1;
  localparam int ST_CR = 0;

  // ----------------------------------------
  // capacity limits
  // ----------------------------------------
  localparam logic [6:0] ROOM_LIMIT = 7'h3f;
  localparam logic [5:0] Q_LIMIT = 6'h1f;
  localparam logic [11:0] LEN_MAX = 12'hfff;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_DATA = 2'b01,
    RX_DROP = 2'b10,
    RX_TAIL = 2'b11
  } hrf_rx_state_t;

  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [31:0] q_end;
    logic [31:0][5:0] q_start;
    logic [31:0][5:0] q_len;
    logic [31:0][12:0] q_cnt;
    logic [4:0] q_rd;
    logic [4:0] q_wr;
    logic [5:0] q_num;
    logic [5:0] wp;
    logic [6:0] used;
    hrf_rx_state_t st;
    logic [5:0] blk_start;
    logic [5:0] blk_cnt;
    logic [11:0] flen;
    logic fov;
    logic floss;
    logic [5:0] wbs;
    logic [1:0] bs_sel;
    logic [2:0] fmode;
    logic lost;
    logic [5:0] rd_off;
    logic wait_q;
    logic [31:0] rdata;
    logic rx_ready;
  } hrf_state_t;

  function automatic logic [5:0] blk_size(input logic [1:0] sel);
    logic [5:0] r;
    unique case (sel)
      2'h0: r = 6'h20;
      2'h1: r = 6'h10;
      2'h2: r = 6'h08;
      2'h3: r = 6'h04;
    endcase
    return r;
  endfunction

  // writes one byte at the write pointer and counts it in the frame
  function automatic hrf_state_t store_byte(input hrf_state_t s, input logic [7:0] b);
    hrf_state_t r;
    r = s;
    r.mem[s.wp] = b;
    r.wp = s.wp + 6'h01;
    r.used = s.used + 7'h01;
    r.blk_cnt = s.blk_cnt + 6'h01;
    if (s.flen == LEN_MAX) r.fov = 1'b1;
    r.flen = s.flen + 12'h001;
    return r;
  endfunction

  // queues one block event with the running frame count
  function automatic hrf_state_t push_ev(input hrf_state_t s, input logic is_end,
                                         input logic [5:0] start, input logic [5:0] len);
    hrf_state_t r;
    r = s;
    r.q_end[s.q_wr] = is_end;
    r.q_start[s.q_wr] = start;
    r.q_len[s.q_wr] = len;
    r.q_cnt[s.q_wr] = {s.fov, s.flen};
    r.q_wr = s.q_wr + 5'h01;
    r.q_num = s.q_num + 6'h01;
    return r;
  endfunction

  localparam hrf_state_t STATE_RESET = '{wait_q: 1'b1, wbs: blk_size(BS_RESET),
                                        fmode: FM_RESET, rx_ready: 1'b1, st: RX_IDLE,
                                        default: '0};

endpackage

// ===== dv/hrf_host_model.sv
// host microcontroller model: avalon master that reads and releases receive blocks
`timescale 1ns/1ps
module hrf_host_model (
  input wire logic core_clk_in,
  input wire logic avs_waitrequest_in,
  input wire logic [31:0] avs_readdata_in,
  output logic [7:0] avs_address_out,
  output logic avs_read_out,
  output logic avs_write_out,
  output logic [31:0] avs_writedata_out,
  output logic [3:0] avs_byteenable_out
);
  initial begin
    avs_address_out = 8'h00;
    avs_read_out = 1'b0;
    avs_write_out = 1'b0;
    avs_writedata_out = 32'h0;
    avs_byteenable_out = 4'hf;
  end

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // no fixed latency assumed; the bench watchdog ends a stuck wait
  task automatic wait_ack();
    @(posedge core_clk_in);
    while (avs_waitrequest_in !== 1'b0) @(posedge core_clk_in);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    avs_address_out <= a;
    avs_read_out <= 1'b1;
    wait_ack();
    d = avs_readdata_in;
    avs_read_out <= 1'b0;
    @(posedge core_clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address_out <= a;
    avs_writedata_out <= d;
    avs_byteenable_out <= be;
    avs_write_out <= 1'b1;
    wait_ack();
    avs_write_out <= 1'b0;
    @(posedge core_clk_in);
  endtask

  // ----------------------------------------
  // commands
  // ----------------------------------------
  // size select written first, so the release picks it up
  task automatic release_blk();
    wr(hrf_pkg::ADDR_CMD, 32'h1 << hrf_pkg::CMD_RELEASE_BIT, 4'h1);
  endtask

  // a mode or initial size change is always followed by a clear
  task automatic set_mode(input logic [31:0] m);
    wr(hrf_pkg::ADDR_MODE, m, 4'h1);
    wr(hrf_pkg::ADDR_CMD, 32'h1 << hrf_pkg::CMD_CLEAR_BIT, 4'h1);
  endtask
endmodule

// ===== dv/testbench.sv
// self-checking bench of the hdlc receive queue controller
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module testbench;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] avs_address_in;
  logic avs_read_in, avs_write_in, avs_waitrequest_out, rx_ready_out;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0] avs_byteenable_in;
  logic rx_byte_valid_in = 1'b0;
  logic [7:0] rx_byte_in = 8'h00;
  logic rx_first_in = 1'b0;
  logic rx_end_in = 1'b0;
  logic rx_crc_ok_in = 1'b0, rx_valid_frame_in = 1'b0, rx_abort_in = 1'b0;
  logic rx_tei_match_in = 1'b0, rx_cr_in = 1'b0;
  logic [1:0] rx_sapi_match_in = 2'h0;
  logic rdy_seen = 1'b1;
  int err_total = 0;
  int n_checks = 0;

  hrf_rx_queue u_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .rx_byte_valid_in(rx_byte_valid_in), .rx_byte_in(rx_byte_in), .rx_first_in(rx_first_in),
    .rx_end_in(rx_end_in), .rx_crc_ok_in(rx_crc_ok_in), .rx_valid_frame_in(rx_valid_frame_in),
    .rx_abort_in(rx_abort_in), .rx_tei_match_in(rx_tei_match_in), .rx_cr_in(rx_cr_in),
    .rx_sapi_match_in(rx_sapi_match_in), .rx_ready_out(rx_ready_out));

  hrf_host_model u_host (.core_clk_in(core_clk_in), .avs_waitrequest_in(avs_waitrequest_out),
    .avs_readdata_in(avs_readdata_out), .avs_address_out(avs_address_in),
    .avs_read_out(avs_read_in), .avs_write_out(avs_write_in),
    .avs_writedata_out(avs_writedata_in), .avs_byteenable_out(avs_byteenable_in));

  always #5 core_clk_in = ~core_clk_in;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    u_host.rd(a, d);
    `CHK(nm, exp, d)
  endtask

  // status order: crc, valid, abort, tei, cr, sapi
  task automatic send_frame(input int n, input logic [7:0] base, input logic [6:0] sts);
    while (rx_ready_out !== 1'b1) @(posedge core_clk_in);
    for (int i = 0; i < n; i++) begin
      rx_byte_in <= base + 8'(i);
      rx_first_in <= (i == 0);
      rx_byte_valid_in <= 1'b1;
      @(posedge core_clk_in);
    end
    rx_byte_valid_in <= 1'b0;
    rx_first_in <= 1'b0;
    {rx_crc_ok_in, rx_valid_frame_in, rx_abort_in, rx_tei_match_in, rx_cr_in,
      rx_sapi_match_in} <= sts;
    rx_end_in <= 1'b1;
    @(posedge core_clk_in);
    rx_end_in <= 1'b0;
    @(posedge core_clk_in);
    rdy_seen = rx_ready_out;
    repeat (2) @(posedge core_clk_in);
  endtask

  task automatic rd_block(input logic [7:0] base, input int n);
    for (int i = 0; i < n; i++) rdchk(hrf_pkg::ADDR_DATA, 32'(base + 8'(i)), "data");
  endtask

  // ----------------------------------------
  // watchdog: whole run needs well under a thousand cycles
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk_in);
    err_total++;
    end_of_test();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    @(posedge core_clk_in);
    rdchk(hrf_pkg::ADDR_MODE, 32'h18, "mode reset");
    rdchk(hrf_pkg::ADDR_IRQ, 32'h0, "irq idle");
    rdchk(hrf_pkg::ADDR_DATA, 32'h0, "data idle");
    rdchk(8'h20, 32'h0, "unmapped");
    u_host.wr(hrf_pkg::ADDR_MODE, 32'h1f, 4'h0);
    rdchk(hrf_pkg::ADDR_MODE, 32'h18, "mode be0");
    // short frame, unfiltered mode: tei, sapi and cr masked
    u_host.set_mode(32'h18);
    send_frame(3, 8'ha1, 7'h7f);
    rdchk(hrf_pkg::ADDR_IRQ, 32'h2, "msg end");
    rdchk(hrf_pkg::ADDR_CNT_LO, 32'h4, "count lo");
    rdchk(hrf_pkg::ADDR_CNT_HI, 32'h0, "count hi");
    rd_block(8'ha1, 3);
    rdchk(hrf_pkg::ADDR_DATA, 32'hb0, "status");
    rdchk(hrf_pkg::ADDR_DATA, 32'ha1, "wrap");
    u_host.release_blk();
    rdchk(hrf_pkg::ADDR_IRQ, 32'h0, "irq freed");
    rdchk(hrf_pkg::ADDR_CNT_LO, 32'h0, "count freed");
    // size 4 working, 32 selected without release; half-read block dropped
    u_host.set_mode(32'h1f);
    u_host.wr(hrf_pkg::ADDR_MODE, 32'h1c, 4'h1);
    send_frame(6, 8'h10, 7'h7f);
    rdchk(hrf_pkg::ADDR_IRQ, 32'h1, "block ready");
    rdchk(hrf_pkg::ADDR_CNT_LO, 32'h4, "block count");
    rd_block(8'h10, 2);
    u_host.release_blk();
    rdchk(hrf_pkg::ADDR_IRQ, 32'h2, "next event");
    rdchk(hrf_pkg::ADDR_CNT_LO, 32'h7, "tail count");
    rd_block(8'h14, 2);
    rdchk(hrf_pkg::ADDR_DATA, 32'hbf, "status sapi");
    u_host.release_blk();
    // frame plus status exactly one block, two-byte full-address mode, size 4
    u_host.set_mode(32'h0f);
    send_frame(3, 8'h30, 7'h7f);
    `CHK("ready kept", 1'b1, rdy_seen)
    rdchk(hrf_pkg::ADDR_IRQ, 32'h2, "full block");
    rdchk(hrf_pkg::ADDR_CNT_LO, 32'h4, "zero tail");
    rd_block(8'h30, 3);
    rdchk(hrf_pkg::ADDR_DATA, 32'hbf, "status addr2");
    u_host.release_blk();
    // data alone fill the block: ready event, then status alone ends the frame
    send_frame(4, 8'h38, 7'h7f);
    `CHK("ready tail", 1'b0, rdy_seen)
    rdchk(hrf_pkg::ADDR_IRQ, 32'h1, "tail ready");
    rd_block(8'h38, 4);
    u_host.release_blk();
    rdchk(hrf_pkg::ADDR_IRQ, 32'h2, "tail end");
    rdchk(hrf_pkg::ADDR_CNT_LO, 32'h5, "lone count");
    rdchk(hrf_pkg::ADDR_DATA, 32'hbf, "lone status");
    u_host.release_blk();
    // three frames fill the store; the fourth is lost whole
    u_host.set_mode(32'h18);
    send_frame(20, 8'h40, 7'h7f);
    send_frame(20, 8'h60, 7'h7f);
    send_frame(20, 8'h80, 7'h7f);
    send_frame(5, 8'hc0, 7'h7f);
    rdchk(hrf_pkg::ADDR_IRQ, 32'h6, "frame lost");
    rdchk(hrf_pkg::ADDR_IRQ, 32'h2, "lost cleared");
    rdchk(hrf_pkg::ADDR_CNT_LO, 32'h15, "frame1 count");
    rd_block(8'h40, 1);
    u_host.release_blk();
    rdchk(hrf_pkg::ADDR_IRQ, 32'h2, "frame2 queued");
    rd_block(8'h60, 2);
    u_host.wr(hrf_pkg::ADDR_CMD, 32'h1 << hrf_pkg::CMD_CLEAR_BIT, 4'h1);
    rdchk(hrf_pkg::ADDR_IRQ, 32'h0, "cleared");
    rdchk(hrf_pkg::ADDR_CNT_LO, 32'h0, "cleared count");
    rdchk(hrf_pkg::ADDR_DATA, 32'h0, "cleared data");
    // frame longer than the free room: late bytes dropped, loss bit set
    send_frame(70, 8'h00, 7'h7f);
    rdchk(hrf_pkg::ADDR_IRQ, 32'h1, "loss ready");
    u_host.release_blk();
    rdchk(hrf_pkg::ADDR_CNT_LO, 32'h40, "loss count");
    rd_block(8'h20, 31);
    rdchk(hrf_pkg::ADDR_DATA, 32'hf0, "loss status");
    end_of_test();
  end
endmodule
